/* adc_link_pkg.sv */
// Purpose: Shared constants for the converter serial port block.
// Assumes: 200 MHz system clock; serial clock slower than system clock.
// Notes: Control word bit 4 is the first bit written on the line.
// Contract
// - Output word leaves most significant bit first.
// - Self-generated serial clock runs no faster than 2.5 MHz.
// - Slave mode accepts 10 MHz clock; 6.25 MHz clock limits sampling rate.
// - Self-clocking mode drives clock and read frame, sends results unprompted.
// - Self-clocking serial clock is a divided-down copy derived from master clock.
// - Read word is leading zero, three address bits, twelve result bits.
// - Control takes first five written bits, loads on sixth serial clock.
// - Mode select low means self-clocking master, high means slave.
package adc_link_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int SCLK_MAX_HZ = 2_500_000;
  localparam int SLAVE_SCLK_MAX_HZ = 10_000_000;
  localparam int SCLK_HALF_CYC =
    (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int PHASE_W = 6;
  localparam int WORD_BITS = 16;
  localparam int RESULT_BITS = 12;
  localparam int ADDR_BITS = 3;
  localparam int CTRL_BITS = 5;
  localparam int CTRL_ADDR_LSB = 2;
  localparam int CTRL_CONV_BIT = 1;
  localparam int CTRL_PD_BIT = 0;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 5'h00;
  localparam logic [4:0] CTRL_LOAD_FALL = 5'h05;
  localparam logic [4:0] LAST_RISE = 5'h0f;
  localparam logic [4:0] SLAVE_DONE_IDX = 5'h10;
  localparam logic [2:0] SLAVE_TAKE_BITS = 3'h5;
  localparam logic [2:0] SLAVE_LOAD_CNT = 3'h6;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_W = 6;
  // Mode bit resets to slave, so no pin is driven before the pin is known.
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h0f;
  localparam int S_MODE = 0;
  localparam int S_RFS = 1;
  localparam int S_TFS = 2;
  localparam int S_CONV = 3;
  localparam int S_WLOAD = 4;
  localparam int S_RDONE = 5;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_XFER = 2'b01
  } master_state_e;
endpackage

/* result_fifo.sv */
// Purpose: Small FIFO between the converter core and the serial shifter.
// Assumes: Single clock; pop only while out_valid is high.
// Notes: in_ready is registered so it reaches the source without a comb path.
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Fill side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic ready_reg, ready_next;
  logic push, pop;

  always_comb begin
    push = in_valid && ready_reg;
    pop = out_ready && (count_reg != '0);
    wptr_next = push ? PW'(wptr_reg + 1'b1) : wptr_reg;
    rptr_next = pop ? PW'(rptr_reg + 1'b1) : rptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = CW'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = CW'(count_reg - 1'b1);
    end
    ready_next = (count_next != FULL_COUNT);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  assign in_ready = ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rptr_reg];
endmodule

/* adc_serial_host_link.sv */
// Purpose: Serial port of an eight-channel converter, device side.
// Assumes: sclk_in is the host clock in slave mode; pins are synchronised.
// Notes: Master mode runs on clk; slave shifting runs on sclk_in.
`timescale 1ns/1ps
module adc_serial_host_link (
  // System clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Mode and conversion trigger pins.
  input wire logic clocking_mode_select,
  input wire logic conversion_trigger_n,
  // Results from the converter core.
  input wire logic result_valid,
  input wire logic [adc_link_pkg::RESULT_BITS-1:0] result_data,
  output logic result_ready,
  // Serial clock pin, split.
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // Read frame pin, split.
  input wire logic read_frame_sync_n,
  output logic read_frame_sync_n_out,
  output logic read_frame_sync_oe,
  // Write frame and data pins.
  input wire logic write_frame_sync_n,
  input wire logic data_in,
  output logic data_out,
  output logic data_out_oe,
  // Control register towards the core.
  output logic [adc_link_pkg::CTRL_BITS-1:0] ctrl_word,
  output logic ctrl_load,
  output logic conv_start
);
  import adc_link_pkg::*;

  logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync3_reg, sync_pin;
  logic din1_reg, din2_reg;
  logic fifo_valid, fifo_pop;
  logic [RESULT_BITS-1:0] fifo_data;
  master_state_e state_reg, state_next;
  logic [PHASE_W-1:0] phase_reg, phase_next;
  logic [4:0] bit_reg, bit_next;
  logic sclk_reg, sclk_next, rd_reg, rd_next, wr_reg, wr_next;
  logic [WORD_BITS-1:0] sh_reg, sh_next, word_reg, word_next;
  logic [CTRL_BITS-1:0] wsh_reg, wsh_next, ctrl_reg, ctrl_next;
  logic load_reg, load_next, conv_reg, conv_next;
  logic rfs_out_reg, rfs_out_next, oe_reg, oe_next;
  logic m_data_reg, m_data_next, pin_oe_reg, pin_oe_next;
  logic slave, m_load, s_load, trig_rise;
  logic [ADDR_BITS-1:0] addr;
  // Link-clock domain.
  logic s_armed, s_data, s_done, s_wloaded;
  logic [4:0] s_idx;
  logic [2:0] s_wcnt;
  logic [CTRL_BITS-1:0] s_wsh;

  result_fifo #(
    .WIDTH(RESULT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(result_valid),
    .in_data(result_data),
    .in_ready(result_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  assign sync_pin = {s_done, s_wloaded, conversion_trigger_n,
                     write_frame_sync_n, read_frame_sync_n,
                     clocking_mode_select};

  // The third stage only feeds edge detectors, never the first stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      sync3_reg <= SYNC_RESET;
      din1_reg <= 1'b0;
      din2_reg <= 1'b0;
    end else begin
      sync1_reg <= sync_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      din1_reg <= data_in;
      din2_reg <= din1_reg;
    end
  end

  always_comb begin
    slave = sync2_reg[S_MODE];
    addr = ctrl_reg[CTRL_ADDR_LSB +: ADDR_BITS];
    m_load = 1'b0;
    fifo_pop = 1'b0;
    state_next = state_reg;
    phase_next = phase_reg;
    bit_next = bit_reg;
    sclk_next = sclk_reg;
    rd_next = rd_reg;
    wr_next = wr_reg;
    sh_next = sh_reg;
    wsh_next = wsh_reg;
    word_next = word_reg;
    unique case (state_reg)
      M_IDLE: begin
        sclk_next = 1'b1;
        if (!slave && (fifo_valid || !sync2_reg[S_TFS])) begin
          // Results go out unprompted as soon as one is ready.
          state_next = M_XFER;
          phase_next = '0;
          bit_next = '0;
          rd_next = fifo_valid;
          wr_next = !sync2_reg[S_TFS];
          fifo_pop = fifo_valid;
          sh_next = {1'b0, addr, fifo_data};
        end else if (slave && sync2_reg[S_RFS] && fifo_valid) begin
          // A new result waits until the current slave read ends.
          fifo_pop = 1'b1;
          word_next = {1'b0, addr, fifo_data};
        end
      end
      M_XFER: begin
        // Divider off clk keeps the clock at or below its ceiling.
        if (phase_reg == PHASE_W'(SCLK_HALF_CYC - 1)) begin
          phase_next = '0;
          sclk_next = !sclk_reg;
          if (sclk_reg) begin
            if (wr_reg && bit_reg < CTRL_LOAD_FALL) begin
              wsh_next = {wsh_reg[CTRL_BITS-2:0], din2_reg};
            end
            m_load = wr_reg && (bit_reg == CTRL_LOAD_FALL);
          end else begin
            bit_next = 5'(bit_reg + 1'b1);
            sh_next = {sh_reg[WORD_BITS-2:0], 1'b0};
            if (bit_reg == LAST_RISE) begin
              state_next = M_IDLE;
              rd_next = 1'b0;
              wr_next = 1'b0;
            end
          end
        end else begin
          phase_next = PHASE_W'(phase_reg + 1'b1);
        end
      end
      default: state_next = M_IDLE;
    endcase
  end

  always_comb begin
    s_load = sync2_reg[S_WLOAD] && !sync3_reg[S_WLOAD];
    trig_rise = sync2_reg[S_CONV] && !sync3_reg[S_CONV];
    ctrl_next = ctrl_reg;
    if (m_load) begin
      ctrl_next = wsh_reg;
    end else if (s_load) begin
      ctrl_next = s_wsh;
    end
    load_next = m_load || s_load;
    conv_next = trig_rise || ((m_load || s_load) && ctrl_next[CTRL_CONV_BIT]);
    rfs_out_next = !(state_next == M_XFER && rd_next);
    m_data_next = sh_next[WORD_BITS-1];
    pin_oe_next = !slave;
    if (slave) begin
      oe_next = !sync2_reg[S_RFS] && !sync2_reg[S_RDONE];
    end else begin
      oe_next = (state_next == M_XFER) && rd_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= M_IDLE;
      phase_reg <= '0;
      bit_reg <= '0;
      sclk_reg <= 1'b1;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      sh_reg <= '0;
      wsh_reg <= '0;
      word_reg <= '0;
      ctrl_reg <= CTRL_RESET;
      load_reg <= 1'b0;
      conv_reg <= 1'b0;
      rfs_out_reg <= 1'b1;
      m_data_reg <= 1'b0;
      oe_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      sclk_reg <= sclk_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      sh_reg <= sh_next;
      wsh_reg <= wsh_next;
      word_reg <= word_next;
      ctrl_reg <= ctrl_next;
      load_reg <= load_next;
      conv_reg <= conv_next;
      rfs_out_reg <= rfs_out_next;
      m_data_reg <= m_data_next;
      oe_reg <= oe_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // Slave read. The frame itself clears the state, since the host clock
  // may stop as soon as the frame ends.
  always_ff @(negedge sclk_in or posedge read_frame_sync_n) begin
    if (read_frame_sync_n) begin
      s_armed <= 1'b0;
    end else begin
      s_armed <= 1'b1;
    end
  end

  always_ff @(posedge sclk_in or posedge read_frame_sync_n) begin
    if (read_frame_sync_n) begin
      s_idx <= 5'h01;
      s_data <= 1'b0;
      s_done <= 1'b0;
    end else if (!s_armed) begin
      s_data <= 1'b0;
    end else if (s_idx == SLAVE_DONE_IDX) begin
      s_done <= 1'b1;
    end else begin
      s_data <= word_reg[4'(WORD_BITS - 1 - int'(s_idx))];
      s_idx <= 5'(s_idx + 1'b1);
    end
  end

  // Slave write. Only the first five bits are kept; the load is flagged
  // on the sixth falling edge.
  always_ff @(negedge sclk_in or posedge write_frame_sync_n) begin
    if (write_frame_sync_n) begin
      s_wcnt <= '0;
      s_wloaded <= 1'b0;
    end else begin
      if (s_wcnt < SLAVE_LOAD_CNT) begin
        s_wcnt <= 3'(s_wcnt + 1'b1);
      end
      if (s_wcnt == SLAVE_TAKE_BITS) begin
        s_wloaded <= 1'b1;
      end
    end
  end

  // Held word is not cleared, so clk still reads it after the frame ends.
  always_ff @(negedge sclk_in) begin
    if (!write_frame_sync_n && s_wcnt < SLAVE_TAKE_BITS) begin
      s_wsh <= {s_wsh[CTRL_BITS-2:0], data_in};
    end
  end

  assign sclk_out = sclk_reg;
  assign sclk_oe = pin_oe_reg;
  assign read_frame_sync_n_out = rfs_out_reg;
  assign read_frame_sync_oe = pin_oe_reg;
  assign data_out = slave ? s_data : m_data_reg;
  assign data_out_oe = oe_reg;
  assign ctrl_word = ctrl_reg;
  assign ctrl_load = load_reg;
  assign conv_start = conv_reg;
endmodule

/* adc_link_props.sv */
// Purpose: Checker for the converter serial port outputs.
// Assumes: Bound to adc_serial_host_link; synchronous active-low reset.
// Notes: Slave-mode timing is judged by the bench, not here.
`timescale 1ns/1ps
module adc_link_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pins.
  input wire logic clocking_mode_select,
  input wire logic conversion_trigger_n,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic read_frame_sync_n_out,
  input wire logic read_frame_sync_oe,
  input wire logic data_out,
  input wire logic data_out_oe,
  // Control outputs.
  input wire logic [adc_link_pkg::CTRL_BITS-1:0] ctrl_word,
  input wire logic ctrl_load,
  input wire logic conv_start
);
  import adc_link_pkg::*;
  logic [5:0] gap_reg;
  logic [4:0] falls_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Saturates so a long idle never wraps into a false short gap.
  always_ff @(posedge clk) begin
    if (!rst_n)
      gap_reg <= 6'h3f;
    else if ($changed(sclk_out))
      gap_reg <= 6'h00;
    else if (gap_reg != 6'h3f)
      gap_reg <= gap_reg + 6'h01;
    if (!rst_n || read_frame_sync_n_out)
      falls_reg <= 5'h00;
    else if ($fell(sclk_out))
      falls_reg <= falls_reg + 5'h01;
  end
  a_clock_half_period: assert property ($changed(sclk_out) |-> gap_reg >= 6'h27)
    else $error("serial clock half period too short");
  a_frame_fall_count: assert property ($rose(read_frame_sync_n_out) |-> falls_reg == 5'h10)
    else $error("read frame did not span sixteen clocks");
  a_lead_zero_bit: assert property ($fell(read_frame_sync_n_out) |-> data_out_oe && !data_out && sclk_out)
    else $error("frame start without leading zero");
  a_shift_on_rise: assert property (!read_frame_sync_n_out && !$past(read_frame_sync_n_out) && $changed(data_out) |-> $rose(sclk_out))
    else $error("data changed off a rising clock");
  a_pins_paired: assert property (sclk_oe == read_frame_sync_oe)
    else $error("clock and frame enables differ");
  a_frame_drives_data: assert property (!read_frame_sync_n_out |-> data_out_oe)
    else $error("read frame without data drive");
  a_slave_no_drive: assert property (clocking_mode_select && $past(clocking_mode_select, 4) |-> !sclk_oe)
    else $error("clock driven in slave mode");
  a_master_drives: assert property (!clocking_mode_select && !$past(clocking_mode_select, 4) && $past(rst_n, 4) |-> sclk_oe)
    else $error("clock not driven in master mode");
  a_load_marks_word: assert property ($changed(ctrl_word) |-> ctrl_load)
    else $error("control changed without load pulse");
  a_trigger_starts: assert property ($rose(conversion_trigger_n) |-> ##[1:4] conv_start)
    else $error("trigger edge gave no start pulse");
endmodule
bind adc_serial_host_link adc_link_props adc_link_props_inst (
  .clk(clk), .rst_n(rst_n), .clocking_mode_select(clocking_mode_select),
  .conversion_trigger_n(conversion_trigger_n), .sclk_out(sclk_out),
  .sclk_oe(sclk_oe), .read_frame_sync_n_out(read_frame_sync_n_out),
  .read_frame_sync_oe(read_frame_sync_oe), .data_out(data_out),
  .data_out_oe(data_out_oe), .ctrl_word(ctrl_word),
  .ctrl_load(ctrl_load), .conv_start(conv_start));

/* host_port_model.sv */
// Purpose: Host serial port driving the converter in slave mode.
// Assumes: 12.5 MHz clock that runs only inside a frame.
// Notes: One shared frame carries a read and a write together.
`timescale 1ns/1ps
module host_port_model (
  // Transfer request and result.
  input wire logic start,
  input wire logic [15:0] wr_word,
  output logic [15:0] rd_word,
  output logic busy,
  // Serial lines.
  output logic sclk,
  output logic frame_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    busy = 1'b0;
    sclk = 1'b0;
    frame_n = 1'b0;
    mosi = 1'b0;
    rd_word = 16'h0000;
    // A rising frame at start clears the link-side state of the converter.
    #1 frame_n = 1'b1;
  end
  always @(posedge start) begin
    busy = 1'b1;
    #17 frame_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #40 sclk = 1'b1;
      mosi = wr_word[i];
      #40 sclk = 1'b0;
      rd_word = {rd_word[14:0], miso};
    end
    #40 frame_n = 1'b1;
    // A released line must not keep its last bit.
    mosi = ~mosi;
    #40 busy = 1'b0;
  end
endmodule

/* test_adc_serial_host_link.sv */
// Purpose: Self-checking bench for the converter serial port.
// Assumes: Host model runs the slave link; master reads follow.
// Notes: Slave word register drains the FIFO; reads return the newest result.
`timescale 1ns/1ps
module test_adc_serial_host_link;
  import adc_link_pkg::*;
  logic clk, rst_n, mode, trig_n, rvalid, rready, ok;
  logic [RESULT_BITS-1:0] rdata;
  logic sclk_out, sclk_oe, frm_out, frm_oe, dout, dout_oe;
  logic [CTRL_BITS-1:0] ctrl;
  logic ctrl_load, conv_start, hstart, hbusy, hsclk, hframe_n, hmosi;
  logic [15:0] hwr, hrd, got;
  logic [31:0] seed;
  logic [2:0] addr;
  logic [RESULT_BITS-1:0] v;
  logic [RESULT_BITS-1:0] q[$];
  int n_fail = 0, checks_done = 0, loads = 0, convs = 0;
  int exp_conv, exp_loads, n, k;
  time t0;
  wire sclk_pin = sclk_oe ? sclk_out : hsclk;
  wire frm_pin = frm_oe ? frm_out : hframe_n;
  adc_serial_host_link adc_serial_host_link_inst (
    .clk(clk), .rst_n(rst_n), .clocking_mode_select(mode),
    .conversion_trigger_n(trig_n), .result_valid(rvalid),
    .result_data(rdata), .result_ready(rready), .sclk_in(sclk_pin),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .read_frame_sync_n(frm_pin),
    .read_frame_sync_n_out(frm_out), .read_frame_sync_oe(frm_oe),
    .write_frame_sync_n(hframe_n), .data_in(hmosi), .data_out(dout),
    .data_out_oe(dout_oe), .ctrl_word(ctrl), .ctrl_load(ctrl_load),
    .conv_start(conv_start));
  host_port_model host_port_model_inst (
    .start(hstart), .wr_word(hwr), .rd_word(hrd), .busy(hbusy),
    .sclk(hsclk), .frame_n(hframe_n), .mosi(hmosi), .miso(dout));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_word(logic [2:0] a, logic [11:0] r);
    return {1'b0, a, r};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic push(input logic [11:0] d, output logic acc);
    @(negedge clk);
    acc = rready;
    rvalid = acc;
    rdata = d;
    @(negedge clk);
    rvalid = 1'b0;
  endtask
  task automatic xfer(input logic [15:0] w);
    @(negedge clk);
    hwr = w;
    hstart = 1'b1;
    for (n = 0; n < 50 && hbusy !== 1'b1; n++) @(negedge clk);
    hstart = 1'b0;
    for (n = 0; n < 900 && hbusy !== 1'b0; n++) @(negedge clk);
    repeat (8) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ctrl_load === 1'b1)
      loads++;
    if (conv_start === 1'b1)
      convs++;
  end
  initial begin
    #100_000;
    n_fail++;
    wrap_up;
  end
  initial begin
    rst_n = 1'b0;
    mode = 1'b1;
    trig_n = 1'b1;
    rvalid = 1'b0;
    rdata = 12'h000;
    hstart = 1'b0;
    hwr = 16'h0000;
    seed = 32'h03c0737c;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    exp_conv = convs;
    addr = 3'h7;
    xfer({addr, 2'b00, seed[10:0]});
    check({11'h000, ctrl}, {11'h000, addr, 2'b00});
    exp_loads = loads + 8;
    for (k = 0; k < 8; k++) begin
      v = (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : seed[11:0];
      seed = lfsr(seed);
      // The slave word register drains the FIFO, so ready never drops.
      push(v, ok);
      check({15'h0000, ok}, 16'h0001);
      got = {seed[15:12], 1'b0, seed[10:0]};
      seed = lfsr(seed);
      exp_conv += got[12];
      xfer(got);
      check(hrd, exp_word(addr, v));
      check({11'h000, ctrl}, {11'h000, got[15:11]});
      addr = got[15:13];
    end
    check(16'(loads), 16'(exp_loads));
    mode = 1'b0;
    repeat (8) @(negedge clk);
    for (k = 0; k < 2; k++) begin
      push(seed[11:0], ok);
      q.push_back(seed[11:0]);
      seed = lfsr(seed);
    end
    repeat (2) begin
      for (n = 0; n < 300 && frm_out !== 1'b0; n++) @(negedge clk);
      for (k = 0; k < 16; k++) begin
        @(negedge sclk_out);
        if (k == 0)
          t0 = $time;
        if (k == 1)
          check(16'($time - t0), 16'h0190);
        got = {got[14:0], dout};
      end
      check(got, exp_word(addr, q.pop_front()));
      for (n = 0; n < 300 && frm_out !== 1'b1; n++) @(negedge clk);
    end
    trig_n = 1'b0;
    repeat (4) @(negedge clk);
    trig_n = 1'b1;
    repeat (8) @(negedge clk);
    check(16'(convs), 16'(exp_conv + 1));
    wrap_up;
  end
endmodule
